// ### mahi_pkg.sv
// package for the multichannel converter host interface
package mahi_pkg;
    localparam int NUM_CH = 8;
    localparam int RES_W = 14;
    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h_ff;
    // idle level of each synchronised pin: select, cs, rd, wr, convert start, ext clock, power down
    localparam logic [6:0] PIN_IDLE = 7'h_7c;
    localparam logic [4:0] FIRST_RESULT_CLKS = 5'h_11;
    localparam logic [4:0] NEXT_RESULT_CLKS = 5'h_03;
    localparam logic [1:0] INT_CLK_DIV = 2'h_1;
    localparam int MCLK_HZ = 10_000_000;
    localparam int INT_CLK_HZ = 10_000_000;
    localparam int LINK_DATA_W = 14;
    typedef enum {ST_IDLE, ST_TRACK, ST_CONV, ST_DONE} mahi_state_type;
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
    } mahi_strobe_type;
endpackage : mahi_pkg

// ### mahi_host_if.sv
`timescale 1ns/10ps
// converter control, channel-enable register and result readout
//
// Summary of operation
// - clock-source select high uses internal 10MHz tick, low uses external clock.
// - internal conversion time is 1.7us for the first channel and grows 0.3us per further active channel.
// - 8-bit channel-enable register, bit n enables channel n.
// - enable bits above implemented channel count are ignored.
// - host writes enable byte on D0-D7, captured on write strobe rising edge.
// - enable writes accepted anytime, applied only at the next convert start.
// - shutdown leaves the channel-enable register unchanged.
// - D0-D7 two-way, D8-D13 output; released while read or select is high.
// - each result is a 14-bit word on the whole data bus.
// - convert start low tracks; rising edge samples and starts conversion.
// - result-ready pulses low per result; last-result goes low at the final one.
// - external clock: first result at 17th clock, then every third clock.
// - full cycle is quiet time plus 16+3(N-1)+1 clock periods.
// - host waits for result-ready to fall before the first read.
// - read low drives result, read high releases; host waits for next ready.
// - a new enable value takes effect at the next convert start falling edge.
// - after completion each read low pulse presents the next result, up to the last one; further reads keep the last word.
// - after reset every channel is enabled.
// - power-down pin high is shutdown, low is normal operation.
module mahi_host_if (
    input wire logic mclk_in, // 10 MHz system clock
    input wire logic rstn_in, // async reset, active low
    input wire mahi_pkg::mahi_strobe_type strb_in, // chip select, read, write (low active)
    input wire logic convert_start_strobe_in, // convert start pin
    input wire logic clock_source_select_in, // 1 internal clock, 0 external
    input wire logic ext_clk_in, // external conversion clock pin
    input wire logic power_down_pin_in, // 1 shutdown
    input wire logic [7:0] data_bus_lines_in, // low data lines from host
    input wire logic [13:0] sample_in [8], // converter core results per channel
    output logic [13:0] data_bus_lines_out, // result onto data lines
    output logic [13:0] data_bus_lines_oe_n_out, // low while driving the line
    output logic result_ready_n_out, // low pulse per result
    output logic last_result_flag_n_out, // low after last result
    output logic [7:0] active_channels_out // applied channel enables
);
    import mahi_pkg::*;

    // three-stage synchronisers for every pin
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
    assign pin_raw = {clock_source_select_in, strb_in.cs_n, strb_in.rd_n, strb_in.wr_n,
                      convert_start_strobe_in, ext_clk_in, power_down_pin_in};
    // reset to each pin's idle level so no false edge follows reset
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    s1_ff[gi] <= PIN_IDLE[gi];
                    s2_ff[gi] <= PIN_IDLE[gi];
                    s3_ff[gi] <= PIN_IDLE[gi];
                    pin_ff[gi] <= PIN_IDLE[gi];
                end else begin
                    s1_ff[gi] <= pin_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        pin_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    wire int_sel = pin_ff[6];
    wire cs_n = pin_ff[5];
    wire rd_n = pin_ff[4];
    wire wr_n = pin_ff[3];
    wire cvst = pin_ff[2];
    wire eclk = pin_ff[1];
    wire sdn = pin_ff[0];
    wire wr_q_n = s3_ff[3];
    wire cvst_q = s3_ff[2];
    wire eclk_q = s3_ff[1];
    wire wr_rise = wr_n == 1'b0 && wr_q_n && s2_ff[3];
    wire cvst_rise = !cvst && cvst_q && s2_ff[2];
    wire cvst_fall = cvst && !cvst_q && !s2_ff[2];
    wire eclk_rise = !eclk && eclk_q && s2_ff[1];
    // a read is open while both filtered select and strobe are low, whichever fell last
    wire bus_rd = !rd_n && !cs_n;

    // internal conversion tick from a divider of the system clock
    localparam int INT_TICK_DIV = MCLK_HZ / INT_CLK_HZ;
    logic [3:0] tick_cnt_ff;
    wire int_tick = tick_cnt_ff == 4'(INT_TICK_DIV - 1);
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt_ff <= 4'h_0;
        end else if (int_tick) begin
            tick_cnt_ff <= 4'h_0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 4'h_1;
        end
    end
    wire conv_tick = int_sel ? int_tick : eclk_rise;

    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h_0;
        for (int i = 0; i < NUM_CH; i++) begin
            n = n + {3'h_0, v[i]};
        end
        return n;
    endfunction : count_ones

    logic [7:0] cfg_ff, act_ff;
    logic [7:0] pend_ff;
    mahi_state_type st_ff;
    logic [5:0] clk_cnt_ff;
    logic [3:0] produced_ff, read_ff;
    logic [13:0] res_ff [8];
    logic [13:0] dout_ff;
    logic oe_n_ff, rdy_n_ff, last_n_ff;
    logic [7:0] impl_mask;
    assign impl_mask = 8'h_ff; // narrower variants clear upper bits here

    // channel-enable register, captured at write rising edge, untouched by shutdown
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_ff <= CFG_RESET;
        end else if (wr_rise && !cs_n) begin
            cfg_ff <= data_bus_lines_in;
        end
    end

    wire [3:0] nact = count_ones(act_ff);
    // k-th enabled channel index, ascending order
    function automatic logic [2:0] nth_ch(input logic [7:0] m, input logic [3:0] k);
        logic [3:0] c;
        logic [2:0] r;
        c = 4'h_0;
        r = 3'h_0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (m[i]) begin
                if (c == k) r = 3'(i);
                c = c + 4'h_1;
            end
        end
        return r;
    endfunction : nth_ch

    wire result_due = (st_ff == ST_CONV) && conv_tick &&
        ((produced_ff == 4'h_0) ? (clk_cnt_ff == 6'(FIRST_RESULT_CLKS - 5'h_01))
                                : (clk_cnt_ff == 6'(NEXT_RESULT_CLKS - 5'h_01)));
    wire [2:0] prod_ch = nth_ch(act_ff, produced_ff);
    wire [2:0] rd_ch = nth_ch(act_ff, read_ff);
    // first cycle of an open read: oe_n_ff still shows the bus released
    wire rd_start = bus_rd && oe_n_ff;
    wire [13:0] rd_word = res_ff[rd_ch];

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= ST_IDLE;
            act_ff <= CFG_RESET;
            clk_cnt_ff <= 6'h_00;
            produced_ff <= 4'h_0;
            rdy_n_ff <= 1'b1;
            last_n_ff <= 1'b1;
        end else begin
            rdy_n_ff <= 1'b1;
            if (sdn) begin
                st_ff <= ST_IDLE;
            end else if (cvst_fall) begin
                act_ff <= cfg_ff & impl_mask;
                last_n_ff <= 1'b1;
                st_ff <= ST_TRACK;
            end else if (cvst_rise && st_ff == ST_TRACK && nact != 4'h_0) begin
                st_ff <= ST_CONV;
                clk_cnt_ff <= 6'h_00;
                produced_ff <= 4'h_0;
            end else if (result_due) begin
                rdy_n_ff <= 1'b0;
                produced_ff <= produced_ff + 4'h_1;
                clk_cnt_ff <= 6'h_00;
                if (produced_ff + 4'h_1 == nact) begin
                    last_n_ff <= 1'b0;
                    st_ff <= ST_DONE;
                end
            end else if (st_ff == ST_CONV && conv_tick) begin
                clk_cnt_ff <= clk_cnt_ff + 6'h_01;
            end
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_res
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    res_ff[gc] <= 14'h_0000;
                end else if (cvst_rise) begin
                    res_ff[gc] <= sample_in[gc]; // all channels held
                end
            end
        end
    endgenerate

    // readout: each read low pulse presents the next result in order until all produced results are read; later reads keep the last word
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            read_ff <= 4'h_0;
            dout_ff <= 14'h_0000;
            oe_n_ff <= 1'b1;
        end else begin
            oe_n_ff <= !bus_rd;
            if (cvst_fall || (cvst_rise && st_ff == ST_TRACK)) begin
                read_ff <= 4'h_0;
            end else if (rd_start && read_ff < produced_ff) begin
                dout_ff <= rd_word;
                read_ff <= read_ff + 4'h_1;
            end
        end
    end

    assign data_bus_lines_out = dout_ff;
    assign data_bus_lines_oe_n_out = {RES_W{oe_n_ff}};
    assign result_ready_n_out = rdy_n_ff;
    assign last_result_flag_n_out = last_n_ff;
    assign active_channels_out = act_ff;

    property p_ready_count;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(last_n_ff) |-> !rdy_n_ff && produced_ff == nact;
    endproperty
    a_ready_count: assert property (p_ready_count) else $error("last flag count wrong");
    property p_bus_release;
        @(posedge mclk_in) disable iff (!rstn_in)
        (rd_n || cs_n) |=> oe_n_ff;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus not released");
    property p_apply;
        @(posedge mclk_in) disable iff (!rstn_in)
        cvst_fall && !sdn |=> act_ff == $past(cfg_ff);
    endproperty
    a_apply: assert property (p_apply) else $error("enable not applied");
    property p_hold;
        @(posedge mclk_in) disable iff (!rstn_in)
        !cvst_fall |=> act_ff == $past(act_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("enable changed early");
    property p_first;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(rdy_n_ff) && produced_ff == 4'h_1 && clock_source_select_in |->
            $past(clk_cnt_ff) == 6'(FIRST_RESULT_CLKS - 5'h_01);
    endproperty
    a_first: assert property (p_first) else $error("first result late");
    property p_clear;
        @(posedge mclk_in) disable iff (!rstn_in)
        cvst_fall && !sdn |=> last_n_ff;
    endproperty
    a_clear: assert property (p_clear) else $error("last flag not cleared");
    property p_reg_keep;
        @(posedge mclk_in) disable iff (!rstn_in)
        $changed(sdn) && !wr_rise |=> cfg_ff == $past(cfg_ff);
    endproperty
    a_reg_keep: assert property (p_reg_keep) else $error("shutdown touched reg");
    property p_write;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_rise && !cs_n |=> cfg_ff == $past(data_bus_lines_in);
    endproperty
    a_write: assert property (p_write) else $error("write not captured");
    sequence s_read_open;
        rd_start && read_ff < produced_ff && !cvst_fall && !cvst_rise;
    endsequence
    sequence s_read_drive;
        !oe_n_ff && dout_ff == $past(rd_word) && read_ff == $past(read_ff) + 4'h_1;
    endsequence
    property p_read_word;
        @(posedge mclk_in) disable iff (!rstn_in)
        s_read_open |=> s_read_drive;
    endproperty
    a_read_word: assert property (p_read_word) else $error("read word not driven");
    property p_shutdown;
        @(posedge mclk_in) disable iff (!rstn_in)
        sdn |=> st_ff == ST_IDLE;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not idle");
    property p_ready_pulse;
        @(posedge mclk_in) disable iff (!rstn_in)
        !rdy_n_ff |=> rdy_n_ff;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse too long");
    property p_next_gap;
        @(posedge mclk_in) disable iff (!rstn_in)
        $fell(rdy_n_ff) && produced_ff > 4'h_1 |->
            $past(clk_cnt_ff) == 6'(NEXT_RESULT_CLKS - 5'h_01);
    endproperty
    a_next_gap: assert property (p_next_gap) else $error("result spacing wrong");
    property p_track_clear;
        @(posedge mclk_in) disable iff (!rstn_in)
        st_ff == ST_TRACK |-> last_n_ff;
    endproperty
    a_track_clear: assert property (p_track_clear) else $error("last flag low in track");
    property p_zero_mask;
        @(posedge mclk_in) disable iff (!rstn_in)
        cvst_rise && st_ff == ST_TRACK && nact == 4'h_0 && !sdn |=> st_ff == ST_TRACK;
    endproperty
    a_zero_mask: assert property (p_zero_mask) else $error("empty mask converted");
endmodule : mahi_host_if

// ### mahi_host_model.sv
`timescale 1ns/10ps
// host bus model: strobes, convert start and the low data lines
module mahi_host_model (
    input wire logic mclk_in, // system clock
    input wire logic [13:0] dout_in, // device result lines
    input wire logic [13:0] oe_n_in, // device line enables
    output mahi_pkg::mahi_strobe_type strb_out, // select, read, write
    output logic conv_out, // convert start
    output logic [7:0] bus_out // resolved low data lines
);
    import mahi_pkg::*;
    logic drv;
    logic [7:0] wd;
    // a released line shows the inverse of the last byte written
    assign bus_out = drv ? wd : (dout_in[7:0] & ~oe_n_in[7:0]) | (~wd & oe_n_in[7:0]);
    initial begin
        strb_out = '1;
        conv_out = 1'b1;
        drv = 1'b0;
        wd = 8'h_00;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : hold
    task automatic write_cfg(input logic [7:0] v);
        strb_out.cs_n = 1'b0;
        strb_out.wr_n = 1'b0;
        wd = v;
        drv = 1'b1;
        hold(8);
        strb_out.wr_n = 1'b1;
        hold(4);
        drv = 1'b0;
        strb_out.cs_n = 1'b1;
        hold(8);
    endtask : write_cfg
    task automatic set_conv(input logic v);
        conv_out = v;
    endtask : set_conv
    task automatic rd(input logic cs_n_v);
        strb_out.cs_n = cs_n_v;
        strb_out.rd_n = 1'b0;
    endtask : rd
    task automatic rd_end(input logic drop_cs);
        strb_out.rd_n = 1'b1;
        if (drop_cs) strb_out.cs_n = 1'b1;
    endtask : rd_end
endmodule : mahi_host_model

// ### test_mahi_host_if.sv
`timescale 1ns/10ps
// self-checking bench for the converter host interface
module test_mahi_host_if;
    import mahi_pkg::*;
    logic mclk;
    logic rstn;
    logic csel;
    logic ext_clk;
    logic ext_run = 1'b0;
    logic pdn;
    logic [13:0] smp [8];
    logic [13:0] dout;
    logic [13:0] oe_n;
    logic rdy_n;
    logic last_n;
    logic [7:0] act;
    logic [7:0] bus;
    logic cvs;
    mahi_strobe_type strb;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int npulse = 0;
    int lastp = 0;
    int rise_cyc = 0;
    logic [7:0] masks [6];
    always #50 mclk = ~mclk;
    // external conversion clock runs only within a frame
    always #500 if (ext_run) ext_clk = ~ext_clk;
    mahi_host_model u_host (.mclk_in(mclk), .dout_in(dout), .oe_n_in(oe_n), .strb_out(strb),
        .conv_out(cvs), .bus_out(bus));
    mahi_host_if i_mahi_host_if (.mclk_in(mclk), .rstn_in(rstn), .strb_in(strb),
        .convert_start_strobe_in(cvs), .clock_source_select_in(csel), .ext_clk_in(ext_clk),
        .power_down_pin_in(pdn), .data_bus_lines_in(bus), .sample_in(smp),
        .data_bus_lines_out(dout), .data_bus_lines_oe_n_out(oe_n),
        .result_ready_n_out(rdy_n), .last_result_flag_n_out(last_n), .active_channels_out(act));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    always @(posedge mclk) begin
        cyc++;
        if (rstn && rdy_n === 1'b0) begin
            npulse++;
            if (npulse == 1 && !ext_run) check(16'(cyc - rise_cyc inside {[17:25]}), 16'h_0001);
            if (npulse > 1 && !ext_run) check(16'(cyc - lastp), 16'h_0003);
            lastp = cyc;
        end
    end
    task automatic run(input logic [7:0] m, input logic [7:0] nxt, input logic ext);
        logic [13:0] q [$];
        int k;
        foreach (smp[c]) smp[c] = 14'($urandom);
        foreach (smp[c]) if (m[c]) q.push_back(smp[c]);
        csel = ~ext;
        u_host.set_conv(1'b0);
        u_host.hold(8);
        check(16'(act), 16'(m));
        check(16'({rdy_n, last_n}), 16'h_0003);
        npulse = 0;
        u_host.set_conv(1'b1);
        rise_cyc = cyc;
        ext_run = ext;
        u_host.write_cfg(nxt);
        check(16'(act), 16'(m));
        for (k = 0; k < 3000 && last_n !== 1'b0; k++) u_host.hold(1);
        if (k == 3000) begin
            err_count++;
            print_verdict();
        end
        u_host.hold(4);
        ext_run = 1'b0;
        check(16'(npulse), 16'($countones(m)));
        // one read past the last result: it is ignored and the last word stands
        for (k = 0; k <= q.size(); k++) begin
            u_host.rd(1'b0);
            u_host.hold(8);
            check(16'(dout), 16'(q[(k < q.size()) ? k : k - 1]));
            check(16'(oe_n), 16'h_0000);
            u_host.rd_end(k[0]);
            u_host.hold(8);
            check(16'(oe_n), 16'h_3fff);
        end
        pdn = 1'b1;
        u_host.hold(10);
        pdn = 1'b0;
        u_host.hold(10);
        check(16'(act), 16'(m));
        $display("run mask=%h ext=%0d done", m, ext);
    endtask : run
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        csel = 1'b1;
        ext_clk = 1'b0;
        pdn = 1'b0;
        void'($urandom(32'h7f2a_62ae));
        foreach (smp[c]) smp[c] = 14'h_0000;
        masks = '{8'h_01, 8'h_80, 8'h_ff, 8'h_00, 8'h_00, 8'h_00};
        for (int i = 3; i < 6; i++) masks[i] = 8'($urandom_range(255, 1));
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        u_host.hold(6);
        check(16'(act), 16'(CFG_RESET));
        u_host.write_cfg(masks[0]);
        for (int i = 0; i < 6; i++) run(masks[i], masks[(i + 1) % 6], i == 1 || i == 4);
        u_host.rd(1'b1);
        u_host.hold(8);
        check(16'(oe_n), 16'h_3fff);
        u_host.rd_end(1'b1);
        $display("select-high read test done");
        print_verdict();
    end
endmodule : test_mahi_host_if
